// >>> src/lad_aux_decoder.sv
// auxiliary command decoder: volume, static indicator, power save, nop, test
`timescale 1ns/1ps
// Summary of operation
// - byte 0x81 enters volume mode; next command byte is the volume value
// - volume value keeps its low six bits; upper two ignored
// - loading the volume value returns decoding to normal
// - 1010110x: x=0 indicator off, x=1 on and awaits indicator byte
// - after indicator-on only the indicator byte is accepted; it ends the mode
// - indicator byte keeps two low bits: off, slow, fast blink, steady
// - indicator changes only through indicator commands and reset
// - all-points-on while display off enters power save
// - power save is standby while the indicator has stayed on since entry, sleep otherwise
// - power save keeps memory and modes; display data writes still pass
// - sleep stops oscillator and supply, outputs held at positive rail
// - standby stops supply and multiplexed drive, oscillator keeps running
// - reset command in standby moves the device to sleep
// - blanking output goes low while in power save
// - byte 0xE3 changes nothing except clearing test mode
// - upper nibble 1111 enters test mode; cleared by pin, reset or nop
// - every mode holds until a command changes it
// - reset command restores volume and indicator defaults, memory untouched
// - 1010010x forces all points on for x=1, normal display for x=0
module lad_aux_decoder #(
    parameter int FRAME_CYC = lad_pkg::FRAME_CYC,
    parameter int SLOW_CYC  = lad_pkg::BLINK_SLOW_CYC,
    parameter int FAST_CYC  = lad_pkg::BLINK_FAST_CYC
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // host bus pins
    input  wire logic       hw_reset_n,
    input  wire logic       cmd_data_select,
    input  wire logic       wr_strobe_n,
    input  wire logic [7:0] data_bus,
    // display data path
    output logic            data_write,
    output logic [7:0]      data_byte,
    // settings
    output logic [5:0]      lcd_drive_level,
    output logic [1:0]      indicator_mode,
    output logic            display_on,
    output logic            all_points_on,
    output logic            test_mode,
    // power state
    output logic            sleep_mode,
    output logic            standby_mode,
    output logic            osc_run,
    output logic            panel_supply_en,
    output logic            drive_hold_vdd,
    output logic            blanking_out_n,
    // static indicator pins
    output logic            frame_polarity_out,
    output logic            static_segment_out
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic        strobe_d;

    // stage one feeds only stage two
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1    <= 11'h7FF;
            sync2    <= 11'h7FF;
            strobe_d <= 1'b1;
        end else begin
            sync1    <= {hw_reset_n, cmd_data_select, wr_strobe_n, data_bus};
            sync2    <= sync1;
            strobe_d <= sync2[8];
        end
    end

    logic       pin_rst;
    logic       wr_take;
    logic       sel_s;
    logic [7:0] byte_s;

    // a write is taken on the rising edge of the strobe, data then settled
    assign pin_rst = ~sync2[10];
    assign sel_s   = sync2[9];
    assign byte_s  = sync2[7:0];
    assign wr_take = sync2[8] & ~strobe_d;

    // ----------------------------------------------------------------
    // command decoding
    // ----------------------------------------------------------------
    lad_pkg::lad_state_e state;
    lad_pkg::lad_state_e next_state;
    logic [5:0] next_vol;
    logic [1:0] next_ind;
    logic       next_disp;
    logic       next_all;
    logic       next_test;
    logic       next_ps;
    logic       next_sleep;
    logic       next_dwr;
    logic [7:0] next_dbyte;
    logic       power_save;
    logic       cmd;

    always_comb begin
        cmd        = wr_take & ~sel_s;
        next_state = state;
        next_vol   = lcd_drive_level;
        next_ind   = indicator_mode;
        next_disp  = display_on;
        next_all   = all_points_on;
        next_test  = test_mode;
        next_dwr   = wr_take & sel_s;
        next_dbyte = sel_s && wr_take ? byte_s : data_byte;
        if (cmd) begin
            case (state)
                lad_pkg::LAD_ST_VOL: begin
                    next_vol   = byte_s[lad_pkg::VOL_W-1:0];
                    next_state = lad_pkg::LAD_ST_IDLE;
                end
                lad_pkg::LAD_ST_IND: begin
                    next_ind   = byte_s[lad_pkg::IND_W-1:0];
                    next_state = lad_pkg::LAD_ST_IDLE;
                end
                default: begin
                    if (byte_s == lad_pkg::OP_VOLUME_MODE) begin
                        next_state = lad_pkg::LAD_ST_VOL;
                    end else if (byte_s[7:1] == lad_pkg::OP_INDICATOR) begin
                        if (byte_s[0]) begin
                            next_state = lad_pkg::LAD_ST_IND;
                        end else begin
                            next_ind = lad_pkg::IND_OFF;
                        end
                    end else if (byte_s[7:1] == lad_pkg::OP_ALL_POINTS) begin
                        next_all = byte_s[0];
                    end else if (byte_s[7:1] == lad_pkg::OP_DISPLAY) begin
                        next_disp = byte_s[0];
                    end else if (byte_s == lad_pkg::OP_RESET) begin
                        next_vol  = lad_pkg::VOL_RESET;
                        next_ind  = lad_pkg::IND_OFF;
                        next_test = 1'b0;
                    end else if (byte_s == lad_pkg::OP_NOP) begin
                        next_test = 1'b0;
                    end else if (byte_s[7:4] == lad_pkg::OP_TEST_NIB) begin
                        next_test = 1'b1;
                    end
                end
            endcase
        end
        // power save: all points on with display off; leaves when either drops
        next_ps = next_all & ~next_disp;
        if (next_ps && !power_save) begin
            next_sleep = (next_ind == lad_pkg::IND_OFF);
        end else if (next_ps && next_ind == lad_pkg::IND_OFF) begin
            next_sleep = 1'b1;
        end else begin
            next_sleep = next_ps & sleep_mode;
        end
    end

    // pin reset acts like the power-on reset on every register here except data_byte, which it holds
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state           <= lad_pkg::LAD_ST_IDLE;
            lcd_drive_level <= lad_pkg::VOL_RESET;
            indicator_mode  <= lad_pkg::IND_OFF;
            display_on      <= 1'b0;
            all_points_on   <= 1'b0;
            test_mode       <= 1'b0;
            power_save      <= 1'b0;
            sleep_mode      <= 1'b0;
            data_write      <= 1'b0;
            data_byte       <= 8'h00;
        end else if (pin_rst) begin
            state           <= lad_pkg::LAD_ST_IDLE;
            lcd_drive_level <= lad_pkg::VOL_RESET;
            indicator_mode  <= lad_pkg::IND_OFF;
            display_on      <= 1'b0;
            all_points_on   <= 1'b0;
            test_mode       <= 1'b0;
            power_save      <= 1'b0;
            sleep_mode      <= 1'b0;
            data_write      <= 1'b0;
            data_byte       <= data_byte;
        end else begin
            state           <= next_state;
            lcd_drive_level <= next_vol;
            indicator_mode  <= next_ind;
            display_on      <= next_disp;
            all_points_on   <= next_all;
            test_mode       <= next_test;
            power_save      <= next_ps;
            sleep_mode      <= next_sleep;
            data_write      <= next_dwr;
            data_byte       <= next_dbyte;
        end
    end

    // ----------------------------------------------------------------
    // power outputs, registered from the power state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            standby_mode    <= 1'b0;
            osc_run         <= 1'b1;
            panel_supply_en <= 1'b1;
            drive_hold_vdd  <= 1'b0;
            blanking_out_n  <= 1'b1;
        end else begin
            standby_mode    <= power_save & ~sleep_mode;
            osc_run         <= ~(power_save & sleep_mode);
            panel_supply_en <= ~power_save;
            drive_hold_vdd  <= power_save;
            blanking_out_n  <= ~power_save;
        end
    end

    // ----------------------------------------------------------------
    // static indicator driver
    // ----------------------------------------------------------------
    lad_blink_if bl ();
    assign bl.mode    = indicator_mode;
    assign bl.osc_run = osc_run;
    assign frame_polarity_out = bl.frame;
    assign static_segment_out = bl.segment;

    lad_blink #(
        .FRAME_CYC (FRAME_CYC),
        .SLOW_CYC  (SLOW_CYC),
        .FAST_CYC  (FAST_CYC)
    ) u_blink (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bl      (bl)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || pin_rst);

    a_vol_mode_enter: assert property (
        cmd && state == lad_pkg::LAD_ST_IDLE && byte_s == lad_pkg::OP_VOLUME_MODE
        |=> state == lad_pkg::LAD_ST_VOL)
        else $error("volume opcode did not enter volume mode");
    a_vol_value_load: assert property (
        cmd && state == lad_pkg::LAD_ST_VOL
        |=> lcd_drive_level == $past(byte_s[5:0]) && state == lad_pkg::LAD_ST_IDLE)
        else $error("volume value not loaded from low six bits");
    a_ind_off_cmd: assert property (
        cmd && state == lad_pkg::LAD_ST_IDLE && byte_s == 8'hAC
        |=> indicator_mode == lad_pkg::IND_OFF && state == lad_pkg::LAD_ST_IDLE)
        else $error("indicator off command not applied");
    a_ind_value_load: assert property (
        cmd && state == lad_pkg::LAD_ST_IND
        |=> indicator_mode == $past(byte_s[1:0]) && state == lad_pkg::LAD_ST_IDLE)
        else $error("indicator byte not loaded");
    a_ind_stable: assert property (
        !(cmd && (state == lad_pkg::LAD_ST_IND || byte_s == 8'hAC || byte_s == 8'hE2))
        |=> $stable(indicator_mode))
        else $error("indicator changed by unrelated command");
    a_ps_entry: assert property (
        cmd && state == lad_pkg::LAD_ST_IDLE && byte_s == {lad_pkg::OP_ALL_POINTS, 1'b1}
        && !display_on |=> power_save)
        else $error("power save not entered");
    a_sleep_outputs: assert property (
        power_save && sleep_mode |=> !osc_run && !panel_supply_en && drive_hold_vdd)
        else $error("sleep outputs wrong");
    a_reset_standby: assert property (
        power_save && !sleep_mode && cmd && byte_s == 8'hE2 && state == lad_pkg::LAD_ST_IDLE
        |=> sleep_mode ##1 !standby_mode && !osc_run)
        else $error("reset command in standby did not go to sleep");
    a_blank_low: assert property (
        $rose(power_save) |=> !blanking_out_n)
        else $error("blanking output not low in power save");
    a_nop_clears: assert property (
        cmd && state == lad_pkg::LAD_ST_IDLE && byte_s == 8'hE3
        |=> !test_mode && $stable(lcd_drive_level) && $stable(indicator_mode))
        else $error("nop changed state or kept test mode");
    a_data_pass: assert property (
        wr_take && sel_s |=> data_write && $stable(state))
        else $error("data write treated as command");

    c_volume_seq: cover property (cmd && state == lad_pkg::LAD_ST_VOL);
    c_standby:    cover property (standby_mode);
    c_sleep:      cover property (power_save && sleep_mode);
    c_test_clear: cover property ($fell(test_mode));
endmodule : lad_aux_decoder

// >>> src/lad_pkg.sv
// constants for the auxiliary command decoder of the lcd driver
package lad_pkg;
    // ----------------------------------------------------------------
    // command byte codes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_VOLUME_MODE = 8'h81;
    localparam logic [6:0] OP_INDICATOR   = 7'h56;  // upper seven bits, bit 0 = on
    localparam logic [6:0] OP_ALL_POINTS  = 7'h52;  // upper seven bits, bit 0 = all on
    localparam logic [6:0] OP_DISPLAY     = 7'h57;  // upper seven bits, bit 0 = on
    localparam logic [7:0] OP_RESET       = 8'hE2;
    localparam logic [7:0] OP_NOP         = 8'hE3;
    localparam logic [3:0] OP_TEST_NIB    = 4'hF;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int         VOL_W         = 6;
    localparam int         IND_W         = 2;
    localparam logic [5:0] VOL_RESET     = 6'h20;
    localparam logic [1:0] IND_OFF       = 2'h0;
    localparam logic [1:0] IND_SLOW      = 2'h1;
    localparam logic [1:0] IND_FAST      = 2'h2;
    localparam logic [1:0] IND_STEADY    = 2'h3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ        = 50_000;
    localparam int BLINK_SLOW_MS  = 1000;
    localparam int BLINK_FAST_MS  = 500;
    localparam int FRAME_MS       = 10;
    localparam int BLINK_SLOW_CYC = BLINK_SLOW_MS * CLK_KHZ;
    localparam int BLINK_FAST_CYC = BLINK_FAST_MS * CLK_KHZ;
    localparam int FRAME_CYC      = FRAME_MS * CLK_KHZ;

    // ----------------------------------------------------------------
    // decoder states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LAD_ST_IDLE = 2'b00,
        LAD_ST_VOL  = 2'b01,
        LAD_ST_IND  = 2'b10
    } lad_state_e;
endpackage : lad_pkg

// >>> src/lad_blink_if.sv
// signals between the command decoder and the static indicator driver
`timescale 1ns/1ps
interface lad_blink_if;
    logic [1:0] mode;
    logic       osc_run;
    logic       frame;
    logic       segment;

    modport ctrl (output mode, output osc_run, input frame, input segment);
    modport drv  (input mode, input osc_run, output frame, output segment);
endinterface : lad_blink_if

// >>> src/lad_blink.sv
// static indicator drive: frame polarity and blinking segment
`timescale 1ns/1ps
module lad_blink #(
    parameter int FRAME_CYC = lad_pkg::FRAME_CYC,
    parameter int SLOW_CYC  = lad_pkg::BLINK_SLOW_CYC,
    parameter int FAST_CYC  = lad_pkg::BLINK_FAST_CYC
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // decoder side
    lad_blink_if.drv  bl
);
    logic [31:0] frame_cnt;
    logic [31:0] blink_cnt;
    logic        phase;
    logic        frame;
    logic        segment;
    logic [31:0] next_frame_cnt;
    logic [31:0] next_blink_cnt;
    logic        next_phase;
    logic        next_frame;
    logic        next_segment;
    logic [31:0] period;
    logic        lit;

    // ----------------------------------------------------------------
    // counters; counters, blink phase and frame clear to zero while the oscillator is stopped
    // ----------------------------------------------------------------
    always_comb begin
        period         = (bl.mode == lad_pkg::IND_FAST) ? 32'(FAST_CYC) : 32'(SLOW_CYC);
        next_frame_cnt = frame_cnt;
        next_blink_cnt = blink_cnt;
        next_phase     = phase;
        next_frame     = frame;
        if (!bl.osc_run) begin
            next_frame_cnt = 32'h0000_0000;
            next_blink_cnt = 32'h0000_0000;
            next_phase     = 1'b0;
            next_frame     = 1'b0;
        end else begin
            if (frame_cnt >= 32'(FRAME_CYC - 1)) begin
                next_frame_cnt = 32'h0000_0000;
                next_frame     = ~frame;
            end else begin
                next_frame_cnt = frame_cnt + 32'h0000_0001;
            end
            if (blink_cnt >= period - 32'h0000_0001) begin
                next_blink_cnt = 32'h0000_0000;
                next_phase     = ~phase;
            end else begin
                next_blink_cnt = blink_cnt + 32'h0000_0001;
            end
        end
        // lit electrode sees the inverted frame, unlit sees the same phase
        lit = (bl.mode == lad_pkg::IND_STEADY) ||
              ((bl.mode == lad_pkg::IND_SLOW || bl.mode == lad_pkg::IND_FAST) && phase);
        next_segment = next_frame ^ lit;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frame_cnt <= 32'h0000_0000;
            blink_cnt <= 32'h0000_0000;
            phase     <= 1'b0;
            frame     <= 1'b0;
            segment   <= 1'b0;
        end else begin
            frame_cnt <= next_frame_cnt;
            blink_cnt <= next_blink_cnt;
            phase     <= next_phase;
            frame     <= next_frame;
            segment   <= next_segment;
        end
    end

    assign bl.frame   = frame;
    assign bl.segment = segment;
endmodule : lad_blink

// >>> test/lad_host_model.sv
// host processor model: writes command and display data bytes on the bus
`timescale 1ns/1ps
module lad_host_model (
    // clock
    input  wire logic       clk_sys,
    // host bus pins
    output logic            hw_reset_n,
    output logic            cmd_data_select,
    output logic            wr_strobe_n,
    output logic [7:0]      data_bus
);
    // ----------------------------------------------------------------
    // bus cycles, all changes on the falling edge
    // ----------------------------------------------------------------
    // idle bus at time zero
    initial begin
        hw_reset_n      = 1'b1;
        cmd_data_select = 1'b0;
        wr_strobe_n     = 1'b1;
        data_bus        = 8'h00;
    end

    // one write cycle; slow stretches the low phase of the strobe
    task automatic write_byte(input logic sel, input logic [7:0] b, input int slow);
        @(negedge clk_sys);
        cmd_data_select = sel;
        data_bus        = b;
        wr_strobe_n     = 1'b0;
        repeat (3 + slow) @(negedge clk_sys);
        wr_strobe_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        data_bus = ~b; // hold time over: never leave a stale byte on the bus
        repeat (3) @(negedge clk_sys);
    endtask : write_byte

    // reset pin held low long enough for the synchroniser
    task automatic pulse_reset();
        @(negedge clk_sys);
        hw_reset_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        hw_reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask : pulse_reset
endmodule : lad_host_model

// >>> test/lad_aux_decoder_bench.sv
// bench for the auxiliary command decoder: host model, queued expectations
`timescale 1ns/1ps
module lad_aux_decoder_bench;
    // ----------------------------------------------------------------
    // clock, reset, wiring
    // ----------------------------------------------------------------
    typedef struct packed { logic [3:0] id; logic [7:0] val; } lad_note_s;
    localparam logic [3:0] K_VOL = 4'h0, K_IND = 4'h1, K_TST = 4'h2, K_SLP = 4'h3,
        K_STB = 4'h4, K_OSC = 4'h5, K_SUP = 4'h6, K_HLD = 4'h7, K_BLK = 4'h8,
        K_DAT = 4'h9, K_CNT = 4'hA, K_FRM = 4'hB, K_DSP = 4'hC;
    string nm [13] = '{"volume", "indicator", "test_mode", "sleep", "standby", "osc_run",
        "supply", "hold_vdd", "blanking_n", "data_byte", "data_count", "frame_moving",
        "display_lit"};
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       hw_reset_n, cmd_data_select, wr_strobe_n, data_write, test_mode;
    logic       sleep_mode, standby_mode, osc_run, panel_supply_en, drive_hold_vdd;
    logic       blanking_out_n, frame_polarity_out;
    logic       static_segment_out, display_on, all_points_on;
    logic       frame_prev = 1'b0;
    logic [7:0] data_bus, data_byte;
    logic [7:0] data_seen = 8'h00;
    logic [5:0] lcd_drive_level;
    logic [1:0] indicator_mode;
    int         frame_edges = 0, edge_base = 0, data_cnt = 0, cycles = 0;
    int         failures = 0, checks = 0, seed = 79204;
    lad_note_s  notes [$];
    event       check_ev;

    always #10 clk_sys = ~clk_sys;

    lad_host_model host_i (.clk_sys(clk_sys), .hw_reset_n(hw_reset_n),
        .cmd_data_select(cmd_data_select), .wr_strobe_n(wr_strobe_n), .data_bus(data_bus));

    // short blink and frame counts keep the run brief
    lad_aux_decoder #(.FRAME_CYC(4), .SLOW_CYC(16), .FAST_CYC(8)) lad_aux_decoder_i (
        .clk_sys(clk_sys), .rst(rst), .hw_reset_n(hw_reset_n),
        .cmd_data_select(cmd_data_select), .wr_strobe_n(wr_strobe_n), .data_bus(data_bus),
        .data_write(data_write), .data_byte(data_byte), .lcd_drive_level(lcd_drive_level),
        .indicator_mode(indicator_mode), .display_on(display_on), .all_points_on(all_points_on),
        .test_mode(test_mode), .sleep_mode(sleep_mode), .standby_mode(standby_mode),
        .osc_run(osc_run), .panel_supply_en(panel_supply_en), .drive_hold_vdd(drive_hold_vdd),
        .blanking_out_n(blanking_out_n), .frame_polarity_out(frame_polarity_out),
        .static_segment_out(static_segment_out));

    // ----------------------------------------------------------------
    // observation and comparison
    // ----------------------------------------------------------------
    // frame edges and data pulses are counted, since a pulse lasts one cycle
    always @(posedge clk_sys) begin
        frame_prev <= frame_polarity_out;
        if (frame_polarity_out !== frame_prev) frame_edges <= frame_edges + 1;
        if (data_write === 1'b1) begin
            data_seen <= data_byte;
            data_cnt  <= data_cnt + 1;
        end
    end

    function automatic logic [7:0] seen(input logic [3:0] id);
        case (id)
            K_VOL:   seen = {2'b00, lcd_drive_level};
            K_IND:   seen = {6'h00, indicator_mode};
            K_TST:   seen = {7'h00, test_mode};
            K_SLP:   seen = {7'h00, sleep_mode};
            K_STB:   seen = {7'h00, standby_mode};
            K_OSC:   seen = {7'h00, osc_run};
            K_SUP:   seen = {7'h00, panel_supply_en};
            K_HLD:   seen = {7'h00, drive_hold_vdd};
            K_BLK:   seen = {7'h00, blanking_out_n};
            K_DAT:   seen = data_seen;
            K_CNT:   seen = data_cnt[7:0];
            K_DSP:   seen = {5'h00, static_segment_out ^ frame_polarity_out,
                             display_on, all_points_on};
            default: seen = {7'h00, frame_edges != edge_base};
        endcase
    endfunction : seen

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, want, got);
        end
    endtask : check

    // second process: oldest note first whenever the driver flags settled outputs
    initial begin
        lad_note_s n;
        forever begin
            @(check_ev);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                check(nm[n.id], seen(n.id), n.val);
            end
        end
    end

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // stimulus helpers
    // ----------------------------------------------------------------
    task automatic exp(input logic [3:0] id, input logic [7:0] v);
        notes.push_back('{id, v});
    endtask : exp

    task automatic settle();
        @(negedge clk_sys);
        ->check_ev;
        @(negedge clk_sys);
    endtask : settle

    task automatic wr(input logic sel, input logic [7:0] v);
        int slow;
        slow = $random(seed) & 1;
        host_i.write_byte(sel, v, slow);
    endtask : wr

    task automatic exp_power(input logic s, t, o, p, h, b);
        exp(K_SLP, {7'h00, s});
        exp(K_STB, {7'h00, t});
        exp(K_OSC, {7'h00, o});
        exp(K_SUP, {7'h00, p});
        exp(K_HLD, {7'h00, h});
        exp(K_BLK, {7'h00, b});
    endtask : exp_power

    task automatic frame_window(input logic moving);
        edge_base = frame_edges;
        repeat (12) @(negedge clk_sys);
        exp(K_FRM, {7'h00, moving});
        settle();
    endtask : frame_window

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int         i;
        logic [7:0] b;
        logic [7:0] vol_exp;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        exp(K_VOL, 8'h20);
        exp(K_IND, 8'h00);
        exp_power(0, 0, 1, 1, 0, 1);
        settle();
        $display("test reset values done");
        // volume pairs: boundaries, a value byte that looks like a test opcode, random
        for (i = 0; i < 6; i++) begin
            b = (i == 0) ? 8'hFF : (i == 1) ? 8'hC0 : (i == 2) ? 8'hF3 :
                (i == 3) ? 8'hA0 : $random(seed);
            wr(0, lad_pkg::OP_VOLUME_MODE);
            wr(0, b);
            vol_exp = {2'b00, b[5:0]};
            exp(K_VOL, vol_exp);
            exp(K_TST, 8'h00);
            settle();
        end
        wr(0, 8'hF5);
        exp(K_VOL, vol_exp);
        exp(K_TST, 8'h01);
        settle();
        wr(0, lad_pkg::OP_NOP);
        exp(K_TST, 8'h00);
        exp(K_VOL, vol_exp);
        settle();
        $display("test volume done");
        for (i = 0; i < 4; i++) begin
            b = $random(seed);
            wr(0, {lad_pkg::OP_INDICATOR, 1'b1});
            wr(0, {b[7:2], i[1:0]});
            exp(K_IND, {6'h00, i[1:0]});
            wr(0, lad_pkg::OP_VOLUME_MODE);
            wr(0, 8'h15);
            wr(0, lad_pkg::OP_NOP);
            exp(K_IND, {6'h00, i[1:0]});
            exp(K_VOL, 8'h15);
            settle();
        end
        wr(0, {lad_pkg::OP_INDICATOR, 1'b0});
        exp(K_IND, 8'h00);
        settle();
        $display("test indicator done");
        wr(1, lad_pkg::OP_VOLUME_MODE);
        wr(0, 8'h15);
        exp(K_DAT, 8'h81);
        exp(K_CNT, 8'h01);
        exp(K_VOL, 8'h15);
        settle();
        wr(0, {lad_pkg::OP_DISPLAY, 1'b0});
        wr(0, {lad_pkg::OP_ALL_POINTS, 1'b1});
        exp_power(1, 0, 0, 0, 1, 0);
        exp(K_DSP, 8'h01);
        frame_window(1'b0);
        wr(1, 8'h5A);
        exp(K_DAT, 8'h5A);
        exp(K_VOL, 8'h15);
        exp(K_SLP, 8'h01);
        settle();
        wr(0, {lad_pkg::OP_ALL_POINTS, 1'b0});
        exp_power(0, 0, 1, 1, 0, 1);
        settle();
        wr(0, {lad_pkg::OP_INDICATOR, 1'b1});
        wr(0, 8'h03);
        wr(0, {lad_pkg::OP_ALL_POINTS, 1'b1});
        exp_power(0, 1, 1, 0, 1, 0);
        exp(K_DSP, 8'h05);
        frame_window(1'b1);
        wr(0, lad_pkg::OP_RESET);
        exp_power(1, 0, 0, 0, 1, 0);
        exp(K_IND, 8'h00);
        exp(K_VOL, 8'h20);
        exp(K_CNT, 8'h02);
        settle();
        wr(0, {lad_pkg::OP_DISPLAY, 1'b1});
        exp(K_DSP, 8'h03);
        exp_power(0, 0, 1, 1, 0, 1);
        settle();
        $display("test power save done");
        for (i = 0; i < 3; i++) begin
            b = $random(seed);
            wr(0, {lad_pkg::OP_TEST_NIB, b[3:0]});
            exp(K_TST, 8'h01);
            settle();
            if (i == 0) wr(0, lad_pkg::OP_NOP);
            else if (i == 1) wr(0, lad_pkg::OP_RESET);
            else host_i.pulse_reset();
            exp(K_TST, 8'h00);
            exp(K_DAT, 8'h5A);
            settle();
        end
        wr(0, lad_pkg::OP_VOLUME_MODE);
        wr(0, 8'h2A);
        repeat (60) @(negedge clk_sys);
        exp(K_VOL, 8'h2A);
        exp(K_IND, 8'h00);
        settle();
        $display("test test mode and hold done");
        end_of_test();
    end
endmodule : lad_aux_decoder_bench
